//--- rtl/rxpuc_pkg.sv
// Package for the receive path power-up control block.
// Assumes one system clock and an APB master on the register side.
package rxpuc_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] RXPUC_OFS_UP = 8'h00;
  localparam logic [7:0] RXPUC_OFS_STATUS = 8'h04;

  // ==========================================================================
  // Field positions of the power-up request register.
  localparam int LOW_NOISE_AMP_UP_REQ = 7;
  localparam int RX_MIXER_UP_REQ = 6;
  localparam int BASEBAND_AMP_UP_REQ = 5;
  localparam int RX_MIXER_BUFFER_UP_REQ = 4;
  localparam int RESERVED_UP_BIT = 3;
  localparam int RX_LOWPASS_UP_REQ = 2;
  localparam int GAIN_AMP_UP_REQ = 1;
  localparam int SAMPLER_UP_REQ = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RXPUC_UP_RESET = 8'hff;
  localparam logic [7:0] RXPUC_EN_RESET = 8'h00;
  localparam logic [7:0] RXPUC_STAGE_MASK = 8'hf7;

  // ==========================================================================
  // Pair decode: both high gives the modem, up only gives off, else on.
  function automatic logic rxpuc_decode(input logic down, input logic up,
                                        input logic modem);
    logic en;
    en = 1'b1;
    if (up && down) begin
      en = modem;
    end else if (up) begin
      en = 1'b0;
    end
    return en;
  endfunction : rxpuc_decode

endpackage : rxpuc_pkg

//--- rtl/rxpuc_stage.sv
// One receive path stage enable, decoded from its request pair.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/10ps
module rxpuc_stage
  import rxpuc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request pair and modem request.
  input wire logic down_req,
  input wire logic up_req,
  input wire logic modem_en,
  // Registered stage enable.
  output logic stage_en
);

  // ==========================================================================
  // Decode and register.
  logic en_d;
  logic en_q;

  always_comb begin
    en_d = rxpuc_decode(down_req, up_req, modem_en);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end

  assign stage_en = en_q;

endmodule : rxpuc_stage

//--- rtl/rxpuc_top.sv
// Receive path power-up request register with APB access and stage enables.
// Assumes the companion power-down bits and the modem enables arrive
// as same-clock inputs from neighbouring logic.
`timescale 1ns/10ps
module rxpuc_top
  import rxpuc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Companion power-down bits and modem enables, one per bit position.
  input wire logic [7:0] STAGE_DOWN_REQ,
  input wire logic [7:0] MODEM_STAGE_EN,
  // Stage enables; bit 3 has no stage and stays low.
  output logic [7:0] STAGE_EN
);

  // ==========================================================================
  // Register state.
  logic [7:0] up_q;
  logic [7:0] up_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic setup;
  logic wr_acc;
  logic [7:0] en_w;

  // ==========================================================================
  // Address decode, shared by the write strobe and the checks below.
  function automatic logic rxpuc_hit_up(input logic [7:0] addr);
    return addr == RXPUC_OFS_UP;
  endfunction : rxpuc_hit_up

  function automatic logic rxpuc_hit_status(input logic [7:0] addr);
    return addr == RXPUC_OFS_STATUS;
  endfunction : rxpuc_hit_status

  assign setup = PSEL && !PENABLE;
  // A write without its low byte lane carries no request bits, so it is dropped quietly.
  assign wr_acc = PSEL && PENABLE && PWRITE && PSTRB[0] && rxpuc_hit_up(PADDR);

  // ==========================================================================
  // Request register.
  always_comb begin
    up_d = up_q;
    if (wr_acc) begin
      up_d = PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      up_q <= RXPUC_UP_RESET;
    end else begin
      up_q <= up_d;
    end
  end

  // ==========================================================================
  // Read path.
  // Reads are prepared in the setup cycle so the access phase needs no wait.
  always_comb begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      case (PADDR)
        RXPUC_OFS_UP: begin
          rdata_d = {24'h00_0000, up_q};
        end
        RXPUC_OFS_STATUS: begin
          err_d = PWRITE;
          rdata_d = {24'h00_0000, en_w};
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // The word was staged in the setup cycle, so every access completes at once.
  assign PREADY = PENABLE;
  assign PRDATA = rdata_q;
  assign PSLVERR = PSEL && PENABLE && err_q;

  // ==========================================================================
  // Stage decoders. Reserved bit 3 drives no stage; software should leave it at 1.
  // Each enable is registered so the analog side never sees a decode glitch.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_stage
      if (g == RESERVED_UP_BIT) begin : g_rsvd
        assign en_w[g] = 1'b0;
      end else begin : g_dec
        rxpuc_stage u_stage (
          .clk(CLK_SYS),
          .rst(RST),
          .down_req(STAGE_DOWN_REQ[g]),
          .up_req(up_q[g]),
          .modem_en(MODEM_STAGE_EN[g]),
          .stage_en(en_w[g])
        );
      end
    end
  endgenerate

  assign STAGE_EN = en_w;

  // ==========================================================================
  // Assertions on the request register and the read path.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_lna_reset_one: assert property ($past(RST) |->
      up_q[LOW_NOISE_AMP_UP_REQ])
    else $error("LNA request not 1 after reset");
  a_lna_write_lands: assert property (wr_acc |=> up_q[LOW_NOISE_AMP_UP_REQ]
      == $past(PWDATA[LOW_NOISE_AMP_UP_REQ]))
    else $error("LNA request write lost");
  a_buf_reset_up: assert property ($past(RST) |->
      up_q[RX_MIXER_BUFFER_UP_REQ])
    else $error("Mixer buffer request not 1 after reset");
  a_up_hold: assert property (!wr_acc |=>
      $stable(up_q))
    else $error("Request register changed without a write");
  a_read_back: assert property (setup && rxpuc_hit_up(PADDR) |=>
      PRDATA == {24'h00_0000, $past(up_q)})
    else $error("Request register read back wrong");
  a_no_err_up: assert property (setup && rxpuc_hit_up(PADDR) |=>
      !err_q)
    else $error("Error flagged on the request register");
  a_status_back: assert property (setup && rxpuc_hit_status(PADDR) |=>
      PRDATA == {24'h00_0000, $past(STAGE_EN)})
    else $error("Status read does not show the stage enables");
  a_status_wr_err: assert property (setup && PWRITE && rxpuc_hit_status(PADDR) |=>
      err_q)
    else $error("Write to the status word not refused");
  a_bad_addr_err: assert property (setup && !rxpuc_hit_up(PADDR)
      && !rxpuc_hit_status(PADDR) |=> err_q && (PRDATA == 32'h0000_0000))
    else $error("Unmapped address not refused");
  a_upper_zero: assert property (
      PRDATA[31:8] == 24'h00_0000)
    else $error("Upper read data bits not zero");

  // ==========================================================================
  // Assertions on the stage enables.
  a_en_reset: assert property ($past(RST) |->
      STAGE_EN == RXPUC_EN_RESET)
    else $error("Stage enables not low after reset");
  a_lna_up_on: assert property (!up_q[LOW_NOISE_AMP_UP_REQ] |=>
      STAGE_EN[LOW_NOISE_AMP_UP_REQ])
    else $error("LNA not on with request 0");
  a_mixer_up_on: assert property (!up_q[RX_MIXER_UP_REQ] |=>
      STAGE_EN[RX_MIXER_UP_REQ])
    else $error("Mixer not on with request 0");
  a_bb_up_on: assert property (!up_q[BASEBAND_AMP_UP_REQ] |=>
      STAGE_EN[BASEBAND_AMP_UP_REQ])
    else $error("Baseband amp not on with request 0");
  a_buf_up_on: assert property (!up_q[RX_MIXER_BUFFER_UP_REQ] |=>
      STAGE_EN[RX_MIXER_BUFFER_UP_REQ])
    else $error("Mixer buffer not on with request 0");
  a_lpf_up_on: assert property (!up_q[RX_LOWPASS_UP_REQ] |=>
      STAGE_EN[RX_LOWPASS_UP_REQ])
    else $error("Low-pass filter not on with request 0");
  a_gain_up_on: assert property (!up_q[GAIN_AMP_UP_REQ] |=>
      STAGE_EN[GAIN_AMP_UP_REQ])
    else $error("Gain amp not on with request 0");
  a_sampler_up_on: assert property (!up_q[SAMPLER_UP_REQ] |=>
      STAGE_EN[SAMPLER_UP_REQ])
    else $error("Sampler not on with request 0");
  a_pair_modem: assert property ((up_q & STAGE_DOWN_REQ & RXPUC_STAGE_MASK) != 8'h00 |=>
      ((STAGE_EN ^ $past(MODEM_STAGE_EN)) & $past(up_q & STAGE_DOWN_REQ)
      & RXPUC_STAGE_MASK) == 8'h00)
    else $error("Modem control pair not followed");
  a_down_off: assert property (##1 (STAGE_EN & $past(up_q & ~STAGE_DOWN_REQ)) == 8'h00)
    else $error("Stage enabled while forced down");
  a_rsvd_off: assert property (!STAGE_EN[RESERVED_UP_BIT])
    else $error("Reserved position drives an enable");

  // ==========================================================================
  // Coverage of the main scenarios.
  c_write_up: cover property (wr_acc);
  c_forced_off: cover property (up_q[LOW_NOISE_AMP_UP_REQ]
      && !STAGE_DOWN_REQ[LOW_NOISE_AMP_UP_REQ]);
  c_modem_ctrl: cover property (up_q[SAMPLER_UP_REQ] && STAGE_DOWN_REQ[SAMPLER_UP_REQ]);
  c_slverr: cover property (PSLVERR);
  c_status_read: cover property (setup && !PWRITE && rxpuc_hit_status(PADDR));

endmodule : rxpuc_top

//--- verif/tb_top.sv
// Testbench for the receive path power-up control block.
// Assumes the bench alone drives APB, the power-down bits and the modem enables.
`timescale 1ns/10ps
module tb_top
  import rxpuc_pkg::*;
;
  // ==========================================================================
  // Stimulus and observation.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] down = 8'h00, modem = 8'h00, stage_en;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  rxpuc_top rxpuc_top_inst (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STAGE_DOWN_REQ(down), .MODEM_STAGE_EN(modem),
    .STAGE_EN(stage_en));
  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // The request stays up until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Enable expected from a down/up pair: only 01 is off, 11 follows the modem.
  function automatic logic [7:0] exp_en(input logic [7:0] d, input logic [7:0] u,
                                        input logic [7:0] m);
    return (~u | (d & m)) & RXPUC_STAGE_MASK;
  endfunction : exp_en
  // ==========================================================================
  // Scenarios.
  task automatic test_reset();
    logic [31:0] r;
    logic e;
    chk(stage_en, 8'h00);
    apb(1'b0, RXPUC_OFS_UP, 32'h0, 4'hf, r, e);
    chk(r, 32'h000000ff);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_decode();
    logic [7:0] uv[6] = '{8'hff, 8'h08, 8'hff, 8'h08, 8'h3c, 8'h89};
    logic [7:0] dv[6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hc6, 8'h7e};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++) begin
      modem <= (i % 2) ? 8'h5a : 8'ha5;
      down <= dv[i];
      apb(1'b1, RXPUC_OFS_UP, {24'h0, uv[i]}, 4'hf, r, e);
      chk(e, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk(stage_en, exp_en(dv[i], uv[i], (i % 2) ? 8'h5a : 8'ha5));
      apb(1'b0, RXPUC_OFS_UP, 32'h0, 4'hf, r, e);
      chk(r, {24'h0, uv[i]});
      apb(1'b0, RXPUC_OFS_STATUS, 32'h0, 4'hf, r, e);
      chk(r, {24'h0, exp_en(dv[i], uv[i], (i % 2) ? 8'h5a : 8'ha5)});
    end
    $display("test_decode done");
  endtask : test_decode
  task automatic test_refuse();
    logic [31:0] r;
    logic e;
    apb(1'b1, RXPUC_OFS_STATUS, 32'h0, 4'hf, r, e);
    chk(e, 1'b1);
    apb(1'b1, 8'h08, 32'h0, 4'hf, r, e);
    chk(e, 1'b1);
    apb(1'b0, 8'h08, 32'h0, 4'hf, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, RXPUC_OFS_UP, 32'h00, 4'he, r, e);
    chk(e, 1'b0);
    apb(1'b0, RXPUC_OFS_UP, 32'h0, 4'hf, r, e);
    chk(r, 32'h00000089);
    $display("test_refuse done");
  endtask : test_refuse
  // A reset in mid-run must bring back the reset word and turn every stage off.
  task automatic test_mid_reset();
    logic [31:0] r;
    logic e;
    down <= 8'h00;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(stage_en, RXPUC_EN_RESET);
    apb(1'b0, RXPUC_OFS_UP, 32'h0, 4'hf, r, e);
    chk(r, {24'h0, RXPUC_UP_RESET});
    #1;
    chk(stage_en, 8'h00);
    $display("test_mid_reset done");
  endtask : test_mid_reset
  // ==========================================================================
  // Run control.
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // A hung handshake is cut short well beyond the hundred or so cycles needed.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    test_reset();
    test_decode();
    test_refuse();
    test_mid_reset();
    final_report();
  end
endmodule : tb_top
